// ---- gpd_port.sv ----
// Purpose: Sixteen-pin direction and data port with edge events.
// Assumes: AHB-Lite single word transfers, asynchronous pin inputs.
// Notes: Zero wait states; every output comes from a flop.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module gpd_port (
    input wire logic i_clk_sys, // System clock
    input wire logic i_nrst, // Async reset, low
    input wire logic i_hsel, // Slave select
    input wire logic [31:0] i_haddr, // Byte address
    input wire logic [1:0] i_htrans, // Transfer type
    input wire logic i_hwrite, // Write when high
    input wire logic [2:0] i_hsize, // Transfer size
    input wire logic [31:0] i_hwdata, // Write data
    input wire logic i_hready, // Bus ready in
    output logic [31:0] o_hrdata, // Read data
    output logic o_hreadyout, // Always ready
    output logic o_hresp, // Always OKAY
    input wire logic [gpd_pkg::GPD_PINS-1:0] i_pin, // Pin levels in
    output logic [gpd_pkg::GPD_PINS-1:0] o_pin, // Pin drive level
    output logic [gpd_pkg::GPD_PINS-1:0] o_pin_oe, // Pin drive enable
    output logic [gpd_pkg::GPD_PINS-1:0] o_pin_event_lines, // Event pulses
    output logic o_irq // Level interrupt
);
    import gpd_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [GPD_PINS-1:0] pin_way; // 1 input, 0 output
    logic [GPD_PINS-1:0] out_val; // Stored output levels
    logic [GPD_PINS-1:0] rise_edge_select; // Hidden rise select
    logic [GPD_PINS-1:0] fall_edge_select; // Hidden fall select
    logic bank_en; // Event enable
    logic [GPD_PINS-1:0] irq_stat; // Sticky event bits
    logic [GPD_PINS-1:0] irq_mask; // Interrupt mask
    logic [GPD_PINS-1:0] pin_sync; // Synchronised pins
    logic [GPD_PINS-1:0] pin_prev; // Previous pin level
    logic wr_pend; // Write data phase due
    logic [7:0] wr_addr; // Latched write offset
    logic [GPD_PINS-1:0] next_pin_way; // Next direction
    logic [GPD_PINS-1:0] next_out_val; // Next output value
    logic [GPD_PINS-1:0] next_rise; // Next rise select
    logic [GPD_PINS-1:0] next_fall; // Next fall select
    logic next_bank_en; // Next enable
    logic [GPD_PINS-1:0] next_irq_stat; // Next status
    logic [GPD_PINS-1:0] next_irq_mask; // Next mask
    logic next_wr_pend; // Next write pending
    logic [7:0] next_wr_addr; // Next write offset
    logic [31:0] next_hrdata; // Next read data
    logic [GPD_PINS-1:0] next_pin; // Next pin level
    logic [GPD_PINS-1:0] next_oe; // Next enable
    logic [GPD_PINS-1:0] next_events; // Next event pulses
    logic next_irq; // Next interrupt
    logic [GPD_PINS-1:0] edges; // Qualified edges
    logic [GPD_PINS-1:0] wdat; // Low half of write data
    logic addr_ok; // Valid address phase

    // ****************************************
    // Helpers
    // ****************************************
    // Read mux, shared by every read offset
    function automatic logic [31:0] rd_word(input logic [7:0] ofs,
        input logic [GPD_PINS-1:0] way, input logic [GPD_PINS-1:0] ov,
        input logic [GPD_PINS-1:0] ins, input logic ben,
        input logic [GPD_PINS-1:0] st, input logic [GPD_PINS-1:0] mk);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (ofs)
            GPD_OFS_BANK_EN: r = {31'h0000_0000, ben};
            GPD_OFS_WAY: r = {16'h0000, way};
            GPD_OFS_OUT: r = {16'h0000, ov};
            GPD_OFS_SET, GPD_OFS_CLR: r = {16'h0000, ov};
            GPD_OFS_IN: r = {16'h0000, ins};
            GPD_OFS_IRQ_STAT: r = {16'h0000, st};
            GPD_OFS_IRQ_MASK: r = {16'h0000, mk};
            // Edge selects and unmapped read zero
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ****************************************
    // Pin input synchroniser
    // ****************************************
    gpd_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_d(i_pin),
        .o_q(pin_sync)
    );

    // ****************************************
    // Bus, registers and events
    // ****************************************
    // Compute next register values
    always_comb begin
        addr_ok = i_hsel && i_hready && i_htrans == GPD_HTRANS_NONSEQ;
        wdat = i_hwdata[GPD_PINS-1:0];
        next_wr_pend = addr_ok && i_hwrite;
        next_wr_addr = addr_ok ? i_haddr[7:0] : wr_addr;
        next_pin_way = pin_way;
        next_out_val = out_val;
        next_rise = rise_edge_select;
        next_fall = fall_edge_select;
        next_bank_en = bank_en;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        // Read data for the coming data phase
        if (addr_ok && !i_hwrite) begin
            next_hrdata = rd_word(i_haddr[7:0], pin_way, out_val,
                pin_sync, bank_en, irq_stat, irq_mask);
        end else begin
            next_hrdata = 32'h0000_0000;
        end
        // Write data phase effects
        if (wr_pend) begin
            case (wr_addr)
                GPD_OFS_BANK_EN: next_bank_en = i_hwdata[GPD_BANK_EN_BIT];
                // Upper write bits dropped
                GPD_OFS_WAY: next_pin_way = wdat;
                GPD_OFS_OUT: next_out_val = wdat;
                // Only ones act, same edge as the write
                GPD_OFS_SET: next_out_val = out_val | wdat;
                GPD_OFS_CLR: next_out_val = out_val & ~wdat;
                GPD_OFS_SET_RISE: next_rise = rise_edge_select | wdat;
                GPD_OFS_CLR_RISE: next_rise = rise_edge_select & ~wdat;
                GPD_OFS_SET_FALL: next_fall = fall_edge_select | wdat;
                GPD_OFS_CLR_FALL: next_fall = fall_edge_select & ~wdat;
                GPD_OFS_IRQ_MASK: next_irq_mask = wdat;
                GPD_OFS_IRQ_STAT: next_irq_stat = irq_stat & ~wdat;
                // Unmapped writes ignored
                default: next_pin_way = pin_way;
            endcase
        end
        // Edge events from synchronised levels, gated by bank enable
        edges = ((pin_sync & ~pin_prev & rise_edge_select)
            | (~pin_sync & pin_prev & fall_edge_select))
            & {GPD_PINS{bank_en}};
        next_events = edges;
        // Set beats clear on the same edge
        next_irq_stat = next_irq_stat | edges;
        next_irq = |(next_irq_stat & next_irq_mask);
        // Driven only where direction bit is 0
        next_oe = ~next_pin_way;
        next_pin = next_out_val & ~next_pin_way;
    end

    // Register everything
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_way <= GPD_WAY_RST;
            out_val <= GPD_ZERO16;
            rise_edge_select <= GPD_ZERO16;
            fall_edge_select <= GPD_ZERO16;
            bank_en <= 1'b0;
            irq_stat <= GPD_ZERO16;
            irq_mask <= GPD_ZERO16;
            pin_prev <= GPD_ZERO16;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_pin <= GPD_ZERO16;
            o_pin_oe <= GPD_ZERO16;
            o_pin_event_lines <= GPD_ZERO16;
            o_irq <= 1'b0;
        end else begin
            pin_way <= next_pin_way;
            out_val <= next_out_val;
            rise_edge_select <= next_rise;
            fall_edge_select <= next_fall;
            bank_en <= next_bank_en;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            pin_prev <= pin_sync;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            o_hrdata <= next_hrdata;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_pin <= next_pin;
            o_pin_oe <= next_oe;
            o_pin_event_lines <= next_events;
            o_irq <= next_irq;
        end
    end
endmodule // gpd_port

// ---- gpd_pkg.sv ----
// Purpose: Constants shared by the sixteen-pin general purpose port.
// Assumes: AHB-Lite slave, 32-bit data, one 100 MHz clock.
// Notes: Offsets are byte addresses of aligned words.
//
// Contract
// - Each pin's direction chosen independently
// - Direction bit 0 is output, 1 input
// - Set port one drives output pin high
// - Clear port one drives output pin low
// - Output value register sets levels directly
// - Zero bits in set/clear do nothing
// - Input pins unaffected by output writes
// - Input level register shows pin states
// - Set/clear port reads return output value
// - Sixteen event lines for interrupt and DMA
// - Edge select bits hidden from software
// - All pins input after reset
// - Input pins are released, not driven
// - Direction in bits 15:0, upper zero
package gpd_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int GPD_PINS = 16;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] GPD_OFS_BANK_EN = 8'h08;
    localparam logic [7:0] GPD_OFS_WAY = 8'h10;
    localparam logic [7:0] GPD_OFS_OUT = 8'h14;
    localparam logic [7:0] GPD_OFS_SET = 8'h18;
    localparam logic [7:0] GPD_OFS_CLR = 8'h1c;
    localparam logic [7:0] GPD_OFS_IN = 8'h20;
    localparam logic [7:0] GPD_OFS_SET_RISE = 8'h24;
    localparam logic [7:0] GPD_OFS_CLR_RISE = 8'h28;
    localparam logic [7:0] GPD_OFS_SET_FALL = 8'h2c;
    localparam logic [7:0] GPD_OFS_CLR_FALL = 8'h30;
    localparam logic [7:0] GPD_OFS_IRQ_STAT = 8'h40;
    localparam logic [7:0] GPD_OFS_IRQ_MASK = 8'h44;
    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [15:0] GPD_WAY_RST = 16'hffff;
    localparam logic [15:0] GPD_ZERO16 = 16'h0000;
    localparam int GPD_BANK_EN_BIT = 0;
    localparam logic [1:0] GPD_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] GPD_HSIZE_WORD = 3'h2;
endpackage

// ---- gpd_sync.sv ----
// Purpose: Two-flop synchroniser for the pin levels.
// Assumes: One clock, asynchronous active-low reset.
// Notes: First stage is read only by the second.
`timescale 1ns/1ns
module gpd_sync (
    input wire logic i_clk_sys, // System clock
    input wire logic i_nrst, // Async reset, low
    input wire logic [gpd_pkg::GPD_PINS-1:0] i_d, // Raw pin levels
    output logic [gpd_pkg::GPD_PINS-1:0] o_q // Synchronised levels
);
    import gpd_pkg::*;
    logic [GPD_PINS-1:0] meta; // First stage
    logic [GPD_PINS-1:0] next_meta; // Next first stage
    logic [GPD_PINS-1:0] next_q; // Next second stage
    // Next values are simply the previous stage
    always_comb begin
        next_meta = i_d;
        next_q = meta;
    end
    // Two stages, cleared at reset
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= next_meta;
            o_q <= next_q;
        end
    end
endmodule // gpd_sync

// ---- gpd_port_properties.sv ----
// Purpose: Bus and pin properties of the sixteen-pin port.
// Assumes: Zero-wait AHB-Lite slave, one clock.
// Notes: Sees only top ports; data phase tracked locally.
`timescale 1ns/1ns
module gpd_port_chk
    import gpd_pkg::*;
(
    input wire logic i_clk_sys, // Clock
    input wire logic i_nrst, // Reset, low
    input wire logic i_hsel, // Select
    input wire logic [31:0] i_haddr, // Address
    input wire logic [1:0] i_htrans, // Type
    input wire logic i_hwrite, // Write
    input wire logic [31:0] i_hwdata, // Write data
    input wire logic i_hready, // Ready in
    input wire logic [31:0] o_hrdata, // Read data
    input wire logic o_hreadyout, // Ready out
    input wire logic o_hresp, // Response
    input wire logic [GPD_PINS-1:0] o_pin, // Drive level
    input wire logic [GPD_PINS-1:0] o_pin_oe // Drive enable
);
    // ****************************************
    // Data phase tracking
    // ****************************************
    logic wr_q; // Write in data phase
    logic rd_q; // Read in data phase
    logic [7:0] a_q; // Offset of data phase
    wire logic tk = i_hsel && i_hready && i_htrans == GPD_HTRANS_NONSEQ;
    // Mirror the address phase one cycle on
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            wr_q <= tk && i_hwrite;
            rd_q <= tk && !i_hwrite;
            a_q <= i_haddr[7:0];
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Writes land at the end of the data phase, pins on the same edge
    a_reset_input: assert property (
        $rose(i_nrst) |-> o_pin_oe == '0)
        else $error("pin driven right after reset");
    a_input_released: assert property (
        (o_pin & ~o_pin_oe) == '0)
        else $error("level shown on a released pin");
    a_way_hold: assert property (
        !(wr_q && a_q == GPD_OFS_WAY) |=> $stable(o_pin_oe))
        else $error("drive enable moved without a direction write");
    a_way_follow: assert property (
        wr_q && a_q == GPD_OFS_WAY |=>
        o_pin_oe == ~$past(i_hwdata[15:0]))
        else $error("drive enable not the inverse of direction");
    a_set_port: assert property (
        wr_q && a_q == GPD_OFS_SET |=>
        o_pin == (($past(o_pin) | $past(i_hwdata[15:0])) & o_pin_oe))
        else $error("set port result wrong");
    a_clear_port: assert property (
        wr_q && a_q == GPD_OFS_CLR |=>
        o_pin == ($past(o_pin) & ~$past(i_hwdata[15:0])))
        else $error("clear port result wrong");
    a_out_value: assert property (
        wr_q && a_q == GPD_OFS_OUT |=>
        o_pin == ($past(i_hwdata[15:0]) & o_pin_oe))
        else $error("output value not driven");
    a_pin_hold: assert property (
        !wr_q |=> $stable(o_pin))
        else $error("pin level moved without a write");
    a_upper_zero: assert property (
        o_hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // Slave never stalls and always answers OKAY
    a_resp_okay: assert property (o_hreadyout && !o_hresp)
        else $error("slave not ready or response not okay");
    c_set: cover property (wr_q && a_q == GPD_OFS_SET);
    c_clr: cover property (wr_q && a_q == GPD_OFS_CLR);
    c_in: cover property (rd_q && a_q == GPD_OFS_IN);
endmodule // gpd_port_chk
bind gpd_port gpd_port_chk i_chk (.i_clk_sys, .i_nrst, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout,
    .o_hresp, .o_pin, .o_pin_oe);

// ---- gpd_pin_model.sv ----
// Purpose: Board side of the sixteen pins.
// Assumes: Board drives every pin the device releases.
// Notes: No contention; a driven pin shows the device level.
`timescale 1ns/1ns
module gpd_pin_model
    import gpd_pkg::*;
(
    input wire logic [GPD_PINS-1:0] i_drv, // Device level
    input wire logic [GPD_PINS-1:0] i_drv_oe, // Device enable
    input wire logic [GPD_PINS-1:0] i_board, // Board level
    output logic [GPD_PINS-1:0] o_level // Wire level
);
    // Released pins take the board level, never a stale drive
    assign o_level = (i_drv & i_drv_oe) | (i_board & ~i_drv_oe);
endmodule // gpd_pin_model

// ---- tb_top.sv ----
// Purpose: Register and pin tests of the sixteen-pin port.
// Assumes: Zero-wait slave; board drives released pins.
// Notes: Expected values worked out by hand from the masks.
`timescale 1ns/1ns
module tb_top;
    import gpd_pkg::*;
    logic clk = 1'b0; // Clock
    logic nrst = 1'b0; // Reset, low
    logic hsel = 1'b0; // Select
    logic [31:0] haddr = '0; // Address
    logic [1:0] htrans = '0; // Type
    logic hwrite = 1'b0; // Write
    logic [31:0] hwdata = '0; // Write data
    logic [15:0] board = 16'h5a3c; // Board levels
    logic [15:0] ev_seen = '0; // Events so far
    logic [31:0] rv; // Read result
    wire logic hready, irq; // Ready, interrupt
    wire logic [31:0] hrdata; // Read data
    wire logic [15:0] pin_in, opin, oe, ev; // Pin nets
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    gpd_port i_gpd_port (.i_clk_sys(clk), .i_nrst(nrst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(GPD_HSIZE_WORD), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_pin(pin_in),
        .o_pin(opin), .o_pin_oe(oe), .o_pin_event_lines(ev), .o_irq(irq));
    gpd_pin_model i_gpd_pin_model (.i_drv(opin), .i_drv_oe(oe),
        .i_board(board), .o_level(pin_in));
    // ****************************************
    // Clock, watchdog, event capture
    // ****************************************
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        ev_seen <= ev_seen | ev; // Pulses are one cycle
        if (cyc == 3000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One single transfer; read data taken at the closing edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= GPD_HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, '0, rv);
        chk("rdata", rv, exp);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("oe", {16'h0, oe}, '0);
        rc(GPD_OFS_WAY, 32'h0000ffff);
        xfer(1'b1, GPD_OFS_WAY, 32'hffff00f0, rv);
        rc(GPD_OFS_WAY, 32'h000000f0);
        chk("oe", {16'h0, oe}, 32'h0000ff0f);
        xfer(1'b1, GPD_OFS_OUT, 32'h0000a5a5, rv);
        rc(GPD_OFS_OUT, 32'h0000a5a5);
        chk("pin", {16'h0, opin}, 32'h0000a505);
        xfer(1'b1, GPD_OFS_SET, 32'h00000112, rv);
        rc(GPD_OFS_SET, 32'h0000a5b7);
        chk("pin", {16'h0, opin}, 32'h0000a507);
        xfer(1'b1, GPD_OFS_CLR, 32'h00008021, rv);
        rc(GPD_OFS_CLR, 32'h00002596);
        chk("pin", {16'h0, opin}, 32'h00002506);
        rc(GPD_OFS_IN, 32'h00002536);
        // Unmapped place: reads zero, write lost
        xfer(1'b1, 8'h0c, 32'hffffffff, rv);
        rc(8'h0c, 32'h00000000);
        rc(GPD_OFS_WAY, 32'h000000f0);
        xfer(1'b1, GPD_OFS_BANK_EN, 32'h00000001, rv);
        xfer(1'b1, GPD_OFS_SET_RISE, 32'h00000040, rv);
        rc(GPD_OFS_SET_RISE, 32'h00000000);
        board <= 16'h5a7c;
        rc(GPD_OFS_IN, 32'h00002536);
        repeat (3) @(posedge clk);
        rc(GPD_OFS_IN, 32'h00002576);
        chk("events", {16'h0, ev_seen}, 32'h00000040);
        rc(GPD_OFS_IRQ_STAT, 32'h00000040);
        chk("irq", {31'h0, irq}, 32'h0);
        // Falling edge on pin 4 through the hidden fall select
        xfer(1'b1, GPD_OFS_SET_FALL, 32'h00000010, rv);
        board <= 16'h5a6c;
        repeat (5) @(posedge clk);
        chk("events", {16'h0, ev_seen}, 32'h00000050);
        rc(GPD_OFS_IRQ_STAT, 32'h00000050);
        xfer(1'b1, GPD_OFS_IRQ_MASK, 32'h00000040, rv);
        rc(GPD_OFS_IRQ_MASK, 32'h00000040);
        chk("irq", {31'h0, irq}, 32'h1);
        xfer(1'b1, GPD_OFS_IRQ_STAT, 32'h00000040, rv);
        rc(GPD_OFS_IRQ_STAT, 32'h00000010);
        chk("irq", {31'h0, irq}, 32'h0);
        // Cleared fall select: pin 4 toggles with no event
        xfer(1'b1, GPD_OFS_CLR_FALL, 32'h00000010, rv);
        board <= 16'h5a7c;
        repeat (5) @(posedge clk);
        board <= 16'h5a6c;
        repeat (5) @(posedge clk);
        chk("events", {16'h0, ev_seen}, 32'h00000050);
        rc(GPD_OFS_IRQ_STAT, 32'h00000010);
        print_verdict();
    end
endmodule // tb_top
